// ### logic/dxm_defs.vh
`ifndef DXM_DEFS_VH
`define DXM_DEFS_VH
// Operation codes
`define OP_NOP      4'h0
`define OP_UNSIGNED_DIVIDE_OP     4'h1
`define OP_SIGNED_DIVIDE_OP     4'h2
`define OP_SIGNED_MIXED_DIVIDE_OP    4'h3
`define OP_CMP      4'h4
`define OP_NEG      4'h5
`define OP_ZERO_EXTEND_OP     4'h6
`define OP_SIGN_EXTEND_OP     4'h7
`define OP_TAS      4'h8
`define OP_MACC     4'h9
`define OP_CLRACC   4'ha
`define OP_LDACC    4'hb
`define OP_STACC    4'hc
// Operand sizes
`define SZ_BYTE     2'h0
`define SZ_WORD     2'h1
`define SZ_LONG     2'h2
// Flag bit positions: N Z V C
`define FLAG_C      0
`define FLAG_V      1
`define FLAG_Z      2
`define FLAG_N      3
// Extension source width select
`define EXT_FROM8   1'b0
`define EXT_FROM16  1'b1
// Test-and-set forced bit
`define TAS_BIT     7
// Accumulator reset value and divider step-count width
`define ACC_RESET   64'h0
`define DIV_STEPS_W 6
`endif

// ### logic/serial_divider.v
`timescale 1ns/10ps
`include "dxm_defs.vh"
// Restoring unsigned divider, one quotient bit per clock
module serial_divider #(
	parameter WIDTH = 32
) (
	input  wire             clk,
	input  wire             rstn,
	input  wire             start,
	input  wire [5:0]       steps,
	input  wire [WIDTH-1:0] dividend,
	input  wire [WIDTH-1:0] divisor,
	output reg              done,
	output reg  [WIDTH-1:0] quotient,
	output reg  [WIDTH-1:0] remainder
);
	reg [5:0]     countQ;
	reg           busyQ;
	reg [WIDTH:0] trial;

	always @* begin
		trial = {remainder, quotient[WIDTH-1]} - {1'b0, divisor};
	end

	always @(posedge clk) begin
		if (!rstn) begin
			countQ    <= 6'h00;
			busyQ     <= 1'b0;
			done      <= 1'b0;
			quotient  <= {WIDTH{1'b0}};
			remainder <= {WIDTH{1'b0}};
		end else begin
			done <= 1'b0;
			if (start) begin
				// Dividend pre-shifted so the top bit is always the next to bring down
				quotient  <= dividend << (WIDTH - steps);
				remainder <= {WIDTH{1'b0}};
				countQ    <= steps;
				busyQ     <= 1'b1;
			end else if (busyQ) begin
				if (trial[WIDTH]) begin
					remainder <= {remainder[WIDTH-2:0], quotient[WIDTH-1]};
					quotient  <= {quotient[WIDTH-2:0], 1'b0};
				end else begin
					remainder <= trial[WIDTH-1:0];
					quotient  <= {quotient[WIDTH-2:0], 1'b1};
				end
				countQ <= countQ - 6'h01;
				if (countQ == 6'h01) begin
					busyQ <= 1'b0;
					done  <= 1'b1;
				end
			end
		end
	end
endmodule // serial_divider

// ### logic/divide_extend_mac_datapath.v
`timescale 1ns/10ps
`include "dxm_defs.vh"
// Overview of operation
// - Same-width divide: 16/16 or 32/32 quotient
// - Mixed divide: quotient and remainder packed together
// - Compare subtracts, sets flags, no writeback
// - Negate writes zero minus operand
// - Zero extend 8 or 16 bits upward
// - Sign extend copies top bit upward
// - Test byte against zero, set bit 7
// - Signed product added into accumulator
// - Load copies register into accumulator
// - Store copies accumulator out, unchanged
module divide_extend_mac_datapath (
	input  wire        clk,
	input  wire        rstn,
	input  wire        opValid,
	input  wire [3:0]  opCode,
	input  wire [1:0]  opSize,
	input  wire        extFrom16,
	input  wire [31:0] srcOperand,
	input  wire [31:0] dstOperand,
	input  wire        memReady,
	input  wire [7:0]  memReadData,
	output wire        opReady,
	output reg         resultValid,
	output reg  [31:0] result,
	output reg         resultWrite,
	output reg  [3:0]  conditionFlags,
	output reg         flagsWrite,
	output reg         divZero,
	output reg         memRead,
	output reg         memWrite,
	output reg  [7:0]  memWriteData,
	output reg         busLock,
	output wire [63:0] accValue
);
	localparam ST_IDLE  = 2'h0;
	localparam ST_DIV   = 2'h1;
	localparam ST_TASRD = 2'h2;
	localparam ST_TASWR = 2'h3;
	reg  [1:0]  stateQ;
	reg  [63:0] accQ;
	reg  [3:0]  divOpQ;
	reg  [1:0]  divSizeQ;
	reg         negQuotQ;
	reg         negRemQ;
	reg  [7:0]  tasByteQ;
	reg         divStart;
	reg  [5:0]  divSteps;
	reg  [31:0] divDividend;
	reg  [31:0] divDivisor;
	wire        divDone;
	wire [31:0] divQuot;
	wire [31:0] divRem;
	// =====================================================
	// Size helpers
	// =====================================================
	function [31:0] maskSize;
		input [31:0] v;
		input [1:0]  sz;
		begin
			case (sz)
				`SZ_BYTE: maskSize = {24'h000000, v[7:0]};
				`SZ_WORD: maskSize = {16'h0000, v[15:0]};
				default:  maskSize = v;
			endcase
		end
	endfunction
	function topBit;
		input [31:0] v;
		input [1:0]  sz;
		begin
			case (sz)
				`SZ_BYTE: topBit = v[7];
				`SZ_WORD: topBit = v[15];
				default:  topBit = v[31];
			endcase
		end
	endfunction
	function [31:0] absVal;
		input [31:0] v;
		input [1:0]  sz;
		begin
			absVal = topBit(v, sz) ? maskSize(32'h0 - v, sz) : maskSize(v, sz);
		end
	endfunction
	// =====================================================
	// Subtract with flags, shared by compare and negate
	// =====================================================
	reg  [31:0] subA;
	reg  [31:0] subB;
	reg  [32:0] subFull;
	reg  [31:0] subRes;
	reg  [3:0]  subFlags;

	always @* begin
		subA = maskSize(dstOperand, opSize);
		subB = maskSize(srcOperand, opSize);
		if (opCode == `OP_NEG) begin
			subB = subA;
			subA = 32'h0;
		end
		subFull = {1'b0, subA} - {1'b0, subB};
		subRes  = maskSize(subFull[31:0], opSize);
		subFlags[`FLAG_N] = topBit(subRes, opSize);
		subFlags[`FLAG_Z] = (subRes == 32'h0);
		subFlags[`FLAG_V] = (topBit(subA, opSize) != topBit(subB, opSize)) &&
			(topBit(subRes, opSize) != topBit(subA, opSize));
		subFlags[`FLAG_C] = (subB > subA);
	end
	// =====================================================
	// Extension
	// =====================================================
	reg [31:0] extRes;

	always @* begin
		if (extFrom16 == `EXT_FROM16)
			extRes = (opCode == `OP_SIGN_EXTEND_OP) ? {{16{dstOperand[15]}}, dstOperand[15:0]}
				: {16'h0000, dstOperand[15:0]};
		else
			extRes = (opCode == `OP_SIGN_EXTEND_OP) ? {{24{dstOperand[7]}}, dstOperand[7:0]}
				: {24'h000000, dstOperand[7:0]};
		extRes = maskSize(extRes, opSize);
	end
	// =====================================================
	// Divider setup; signs handled outside the unsigned core
	// =====================================================
	wire       isDiv    = (opCode == `OP_UNSIGNED_DIVIDE_OP) || (opCode == `OP_SIGNED_DIVIDE_OP) || (opCode == `OP_SIGNED_MIXED_DIVIDE_OP);
	wire [1:0] dvsrSize = (opCode == `OP_SIGNED_MIXED_DIVIDE_OP) ? ((opSize == `SZ_BYTE) ? `SZ_BYTE : `SZ_WORD)
		: ((opSize == `SZ_WORD) ? `SZ_WORD : `SZ_LONG);
	wire [1:0] dvdSize  = (opCode == `OP_SIGNED_MIXED_DIVIDE_OP) ? ((opSize == `SZ_BYTE) ? `SZ_WORD : `SZ_LONG) : dvsrSize;
	wire       signedDv = (opCode != `OP_UNSIGNED_DIVIDE_OP);
	wire       dvdNeg   = signedDv && topBit(dstOperand, dvdSize);
	wire       dvsrNeg  = signedDv && topBit(srcOperand, dvsrSize);
	wire       dvsrZero = (maskSize(srcOperand, dvsrSize) == 32'h0);

	always @* begin
		divStart    = opValid && (stateQ == ST_IDLE) && isDiv && !dvsrZero;
		divDividend = signedDv ? absVal(dstOperand, dvdSize) : maskSize(dstOperand, dvdSize);
		divDivisor  = signedDv ? absVal(srcOperand, dvsrSize) : maskSize(srcOperand, dvsrSize);
		divSteps    = (dvdSize == `SZ_WORD) ? 6'h10 : 6'h20;
	end

	serial_divider #(.WIDTH(32)) divider (
		.clk       (clk),
		.rstn      (rstn),
		.start     (divStart),
		.steps     (divSteps),
		.dividend  (divDividend),
		.divisor   (divDivisor),
		.done      (divDone),
		.quotient  (divQuot),
		.remainder (divRem)
	);

	wire [31:0] qSigned = negQuotQ ? (32'h0 - divQuot) : divQuot;
	wire [31:0] rSigned = negRemQ ? (32'h0 - divRem) : divRem;
	// =====================================================
	// Multiply-accumulate
	// =====================================================
	wire signed [63:0] product = $signed(srcOperand) * $signed(dstOperand);

	assign accValue = accQ;
	assign opReady  = (stateQ == ST_IDLE);
	// =====================================================
	// Sequencer
	// =====================================================
	always @(posedge clk) begin
		if (!rstn) begin
			stateQ         <= ST_IDLE;
			accQ           <= `ACC_RESET;
			divOpQ         <= `OP_NOP;
			divSizeQ       <= `SZ_BYTE;
			negQuotQ       <= 1'b0;
			negRemQ        <= 1'b0;
			tasByteQ       <= 8'h00;
			resultValid    <= 1'b0;
			result         <= 32'h0;
			resultWrite    <= 1'b0;
			conditionFlags <= 4'h0;
			flagsWrite     <= 1'b0;
			divZero        <= 1'b0;
			memRead        <= 1'b0;
			memWrite       <= 1'b0;
			memWriteData   <= 8'h00;
			busLock        <= 1'b0;
		end else begin
			resultValid <= 1'b0;
			resultWrite <= 1'b0;
			flagsWrite  <= 1'b0;
			divZero     <= 1'b0;
			case (stateQ)
				ST_IDLE: begin
					if (opValid) begin
						case (opCode)
							`OP_UNSIGNED_DIVIDE_OP, `OP_SIGNED_DIVIDE_OP, `OP_SIGNED_MIXED_DIVIDE_OP: begin
								if (dvsrZero) begin
									// Zero divisor: destination left untouched
									divZero     <= 1'b1;
									resultValid <= 1'b1;
									result      <= dstOperand;
								end else begin
									divOpQ   <= opCode;
									divSizeQ <= opSize;
									negQuotQ <= dvdNeg ^ dvsrNeg;
									negRemQ  <= dvdNeg;
									stateQ   <= ST_DIV;
								end
							end
							`OP_CMP: begin
								conditionFlags <= subFlags;
								flagsWrite     <= 1'b1;
								resultValid    <= 1'b1;
								result         <= dstOperand;
							end
							`OP_NEG: begin
								result         <= subRes;
								resultWrite    <= 1'b1;
								resultValid    <= 1'b1;
								conditionFlags <= subFlags;
								flagsWrite     <= 1'b1;
							end
							`OP_ZERO_EXTEND_OP, `OP_SIGN_EXTEND_OP: begin
								result      <= extRes;
								resultWrite <= 1'b1;
								resultValid <= 1'b1;
							end
							`OP_TAS: begin
								busLock <= 1'b1;
								memRead <= 1'b1;
								stateQ  <= ST_TASRD;
							end
							`OP_MACC: begin
								accQ        <= accQ + product;
								resultValid <= 1'b1;
							end
							`OP_CLRACC: begin
								accQ        <= 64'h0;
								resultValid <= 1'b1;
							end
							`OP_LDACC: begin
								accQ        <= {{32{srcOperand[31]}}, srcOperand};
								resultValid <= 1'b1;
							end
							`OP_STACC: begin
								result      <= accQ[31:0];
								resultWrite <= 1'b1;
								resultValid <= 1'b1;
							end
							default: resultValid <= 1'b1;
						endcase
					end
				end
				ST_DIV: begin
					if (divDone) begin
						// Mixed form packs remainder above quotient
						if (divOpQ == `OP_SIGNED_MIXED_DIVIDE_OP) begin
							if (divSizeQ == `SZ_BYTE)
								result <= {16'h0000, rSigned[7:0], qSigned[7:0]};
							else
								result <= {rSigned[15:0], qSigned[15:0]};
						end else begin
							result <= maskSize(qSigned, divSizeQ);
						end
						resultWrite <= 1'b1;
						resultValid <= 1'b1;
						stateQ      <= ST_IDLE;
					end
				end
				ST_TASRD: begin
					if (memReady) begin
						memRead                  <= 1'b0;
						tasByteQ                 <= memReadData;
						conditionFlags           <= {memReadData[7], (memReadData == 8'h00), 2'h0};
						flagsWrite               <= 1'b1;
						memWrite                 <= 1'b1;
						memWriteData             <= memReadData | (8'h01 << `TAS_BIT);
						stateQ                   <= ST_TASWR;
					end
				end
				ST_TASWR: begin
					if (memReady) begin
						memWrite    <= 1'b0;
						busLock     <= 1'b0;
						resultValid <= 1'b1;
						result      <= {24'h000000, tasByteQ};
						stateQ      <= ST_IDLE;
					end
				end
				default: stateQ <= ST_IDLE;
			endcase
		end
	end
endmodule // divide_extend_mac_datapath

// ### testbench/mem_partner.sv
`timescale 1ns/10ps
// ==========
// Byte memory seen by test-and-set
module mem_partner (
	input  wire       clk,
	input  wire       rstn,
	input  wire       memRead,
	input  wire       memWrite,
	input  wire [7:0] memWriteData,
	input  wire [7:0] memByte,
	input  wire       slow,
	output reg        memReady,
	output reg  [7:0] lastWrite,
	output wire [7:0] memReadData
);
	reg [1:0] cnt;
	// Inverted outside reads so a stale byte never passes
	assign memReadData = memRead ? memByte : ~memByte;
	always @(posedge clk) begin
		// Reload while idle so the slow setting delays every handshake
		if (!rstn || memReady || !(memRead || memWrite)) begin
			memReady <= 1'b0;
			cnt <= slow ? 2'h3 : 2'h0;
		end else if (memRead || memWrite) begin
			if (cnt == 2'h0)
				memReady <= 1'b1;
			else
				cnt <= cnt - 2'h1;
		end
		if (memReady && memWrite)
			lastWrite <= memWriteData;
	end
endmodule // mem_partner

// ### testbench/divide_extend_mac_datapath_monitor.sv
`timescale 1ns/10ps
module divide_extend_mac_datapath_monitor (
	input wire        clk,
	input wire        rstn,
	input wire        opValid,
	input wire [3:0]  opCode,
	input wire [1:0]  opSize,
	input wire        extFrom16,
	input wire [31:0] srcOperand,
	input wire [31:0] dstOperand,
	input wire        opReady,
	input wire        resultValid,
	input wire [31:0] result,
	input wire        resultWrite,
	input wire        flagsWrite,
	input wire        memRead,
	input wire        memWrite,
	input wire [7:0]  memWriteData,
	input wire        busLock,
	input wire [63:0] accValue
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire take = opValid && opReady;
	// ==========
	// Checks
	// Zero divisor answers at once, so it is kept out of the bound
	a_div_bound: assert property (take && opCode == 4'h1 && opSize == 2'h2 && srcOperand != 32'h0
		|=> !opReady ##[1:34] resultValid)
		else $error("divide answer late");
	a_cmp_flags_only: assert property (take && opCode == 4'h4
		|=> flagsWrite && resultValid && !resultWrite)
		else $error("compare wrote result");
	a_neg_value: assert property (take && opCode == 4'h5 && opSize == 2'h2
		|=> result == 32'h0 - $past(dstOperand))
		else $error("negate value");
	a_zext_byte: assert property (take && opCode == 4'h6 && opSize == 2'h2 && !extFrom16
		|=> result == {24'h0, $past(dstOperand[7:0])})
		else $error("zero extend value");
	a_sext_half: assert property (take && opCode == 4'h7 && opSize == 2'h2 && extFrom16
		|=> result == {{16{$past(dstOperand[15])}}, $past(dstOperand[15:0])})
		else $error("sign extend value");
	a_tas_bit7: assert property (memWrite |-> memWriteData[7] && busLock)
		else $error("write-back bit or lock");
	a_tas_lock: assert property (take && opCode == 4'h8 |=> busLock && memRead)
		else $error("lock not taken");
	a_clr_zero: assert property (take && opCode == 4'ha |=> accValue == 64'h0)
		else $error("clear failed");
	a_ld_copy: assert property (take && opCode == 4'hb
		|=> accValue == {{32{$past(srcOperand[31])}}, $past(srcOperand)})
		else $error("load failed");
	a_st_keep: assert property (take && opCode == 4'hc
		|=> resultWrite && result == accValue[31:0] && $stable(accValue))
		else $error("store failed");
	c_tas: cover property (take && opCode == 4'h8);
	c_mac: cover property (take && opCode == 4'h9);
	c_signed_mixed_divide_op: cover property (take && opCode == 4'h3);
	c_divzero: cover property (take && opCode == 4'h2 && srcOperand == 32'h0);
endmodule // divide_extend_mac_datapath_monitor
bind divide_extend_mac_datapath divide_extend_mac_datapath_monitor mon (
	.clk          (clk),
	.rstn         (rstn),
	.opValid      (opValid),
	.opCode       (opCode),
	.opSize       (opSize),
	.extFrom16    (extFrom16),
	.srcOperand   (srcOperand),
	.dstOperand   (dstOperand),
	.opReady      (opReady),
	.resultValid  (resultValid),
	.result       (result),
	.resultWrite  (resultWrite),
	.flagsWrite   (flagsWrite),
	.memRead      (memRead),
	.memWrite     (memWrite),
	.memWriteData (memWriteData),
	.busLock      (busLock),
	.accValue     (accValue)
);

// ### testbench/divide_extend_mac_datapath_tb.sv
`timescale 1ns/10ps
module divide_extend_mac_datapath_tb;
	reg clk, rstn, opValid, extFrom16, slow;
	reg [3:0] opCode;
	reg [1:0] opSize;
	reg [31:0] srcOperand, dstOperand;
	reg [7:0] memByte;
	wire memReady, opReady, resultValid, resultWrite, flagsWrite, divZero, memRead, memWrite, busLock;
	wire [7:0] memReadData, memWriteData, lastWrite;
	wire [31:0] result;
	wire [3:0] conditionFlags;
	wire [63:0] accValue;
	integer nFail = 0, checked = 0;
	divide_extend_mac_datapath dut (.clk(clk), .rstn(rstn), .opValid(opValid), .opCode(opCode), .opSize(opSize),
		.extFrom16(extFrom16), .srcOperand(srcOperand), .dstOperand(dstOperand), .memReady(memReady),
		.memReadData(memReadData), .opReady(opReady), .resultValid(resultValid), .result(result),
		.resultWrite(resultWrite), .conditionFlags(conditionFlags), .flagsWrite(flagsWrite), .divZero(divZero),
		.memRead(memRead), .memWrite(memWrite), .memWriteData(memWriteData), .busLock(busLock), .accValue(accValue));
	mem_partner mem (.clk(clk), .rstn(rstn), .memRead(memRead), .memWrite(memWrite), .memWriteData(memWriteData),
		.memByte(memByte), .slow(slow), .memReady(memReady), .lastWrite(lastWrite), .memReadData(memReadData));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// ==========
	// Shared tasks
	task chk(input string nm, input [63:0] seen, input [63:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				nFail = nFail + 1;
				$display("mismatch %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", checked, nFail);
			if (nFail == 0 && checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// Idle before each request, so one edge always takes it
	task run(input [3:0] c, input [1:0] s, input e, input [31:0] a, input [31:0] b);
		integer i;
		begin
			@(negedge clk);
			{opCode, opSize, extFrom16, srcOperand, dstOperand, opValid} = {c, s, e, a, b, 1'b1};
			@(negedge clk);
			opValid = 0;
			for (i = 0; i < 60 && resultValid !== 1'b1; i = i + 1)
				@(negedge clk);
			chk("done", resultValid, 1);
		end
	endtask
	// ==========
	// Scenarios
	task t_divide;
		begin
			run(4'h1, 2'h1, 0, 32'h7, 32'h64);
			chk("unsigned_divide_op", result[15:0], 16'h000e);
			run(4'h2, 2'h2, 0, 32'h7, 32'hffffff9c);
			chk("signed_divide_op", result, 32'hfffffff2);
			run(4'h1, 2'h2, 0, 32'h7, 32'h64);
			chk("divul", result, 32'he);
			run(4'h3, 2'h1, 0, 32'h7, 32'hffffff9c);
			chk("divxw", result, 32'hfffefff2);
			run(4'h3, 2'h0, 0, 32'h7, 32'h0000ff9c);
			chk("divxb", result, 32'h0000fef2);
			// Zero divisor leaves the destination alone
			run(4'h2, 2'h2, 0, 32'h0, 32'h1234);
			chk("divz", divZero, 1);
			chk("divzw", resultWrite, 0);
			chk("divzr", result, 32'h1234);
		end
	endtask
	task t_compare;
		begin
			run(4'h4, 2'h2, 0, 32'h5, 32'h3);
			chk("cmpf", conditionFlags, 4'h9);
			chk("cmpw", resultWrite, 0);
			run(4'h4, 2'h0, 0, 32'h5, 32'h5);
			chk("cmpz", conditionFlags[2], 1);
		end
	endtask
	task t_negext;
		begin
			run(4'h5, 2'h2, 0, 32'h0, 32'h5);
			chk("neg", result, 32'hfffffffb);
			run(4'h5, 2'h1, 0, 32'h0, 32'h1);
			chk("negw", result[15:0], 16'hffff);
			run(4'h6, 2'h2, 0, 32'h0, 32'h12345680);
			chk("zext", result, 32'h80);
			run(4'h6, 2'h1, 0, 32'h0, 32'h12345680);
			chk("zextw", result[15:0], 16'h0080);
			run(4'h7, 2'h2, 0, 32'h0, 32'h12345680);
			chk("sext", result, 32'hffffff80);
			run(4'h7, 2'h2, 1, 32'h0, 32'h12348001);
			chk("sext16", result, 32'hffff8001);
		end
	endtask
	task t_testset(input [7:0] b, input s);
		begin
			memByte = b;
			slow = s;
			run(4'h8, 2'h0, 0, 32'h0, 32'h0);
			chk("tasz", conditionFlags[2], b == 8'h0);
			chk("tasw", lastWrite, b | 8'h80);
			chk("tasr", result[7:0], b);
			chk("lock", busLock, 0);
		end
	endtask
	task t_accum;
		begin
			run(4'ha, 2'h2, 0, 32'h0, 32'h0);
			chk("clr", accValue, 64'h0);
			run(4'hb, 2'h2, 0, 32'h5, 32'h0);
			chk("ld", accValue, 64'h5);
			run(4'h9, 2'h2, 0, 32'hfffffffd, 32'h4);
			chk("mac", accValue, 64'hfffffffffffffff9);
			run(4'hc, 2'h2, 0, 32'h0, 32'h0);
			chk("st", result, 32'hfffffff9);
			chk("stacc", accValue, 64'hfffffffffffffff9);
		end
	endtask
	// Mid-run reset must clear the accumulator and the result
	task t_reset;
		begin
			@(negedge clk);
			rstn = 0;
			repeat (2) @(negedge clk);
			chk("rstacc", accValue, 64'h0);
			chk("rstres", result, 32'h0);
			chk("rstrdy", opReady, 1);
			rstn = 1;
			run(4'hb, 2'h2, 0, 32'h9, 32'h0);
			chk("rstld", accValue, 64'h9);
		end
	endtask
	initial begin
		{rstn, opValid, extFrom16, slow, opCode, opSize, srcOperand, dstOperand, memByte} = 0;
		repeat (20) @(negedge clk);
		rstn = 1;
		t_divide;
		t_compare;
		t_negext;
		t_testset(8'h00, 0);
		t_testset(8'h41, 1);
		t_accum;
		t_reset;
		report_and_stop;
	end
	// Roughly five times the expected run
	initial begin
		#115000;
		nFail = nFail + 1;
		report_and_stop;
	end
endmodule // divide_extend_mac_datapath_tb
